// ===== dv/fcl_loader_test.sv
// bench for the fuse loader: loads after reset, hold-offs, bus access, erase, debug
// assumes a zero-wait slave and a hold count shortened to four slow edges
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, sn) begin checked++; if ((sn) !== (ex)) begin fails++; \
  $display("mismatch %s expected %h seen %h", nm, ex, sn); end end

module fcl_loader_test
  import fcl_pkg::*;
;
  localparam int HOLD = 4;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic por_flag = 1'b0;
  logic device_locked = 1'b0;
  logic slow_osc_in = 1'b0;
  logic debug_entry = 1'b0;
  fcl_fuse_s fuse_in = '0;
  fcl_cal_s cal16 = {8'ha1, 7'h23};
  fcl_cal_s cal20 = {8'hb7, 7'h4c};
  logic hready, hreadyout, hresp, cdl, nvm_block, pin_off, er_f, er_e;
  logic [31:0] hrdata, rd;
  fcl_wdt_s wdt_control;
  fcl_bod_s bod_control;
  logic [1:0] freq, crc, pin_fn;
  logic [7:0] cal_a, cal_b, tdf;
  int fails = 0;
  int checked = 0;
  int n_cdl = 0;
  int n_ef = 0;
  int n_ee = 0;

  ////////////////////////////////////////////////////////////////////////////
  // clock, single slave so hready is the slave's own answer
  always #2 hclk = ~hclk;
  assign hready = hreadyout;

  fcl_loader #(.BLOCK_CYCLES(HOLD)) dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .fuse_in(fuse_in),
    .factory_cal_16m(cal16), .factory_cal_20m(cal20), .por_flag(por_flag),
    .device_locked(device_locked), .slow_osc_in(slow_osc_in), .debug_entry(debug_entry),
    .wdt_control(wdt_control), .bod_control(bod_control), .osc_frequency_select(freq),
    .osc_calibration_a(cal_a), .osc_calibration_b(cal_b), .timer_d_fault_control(tdf),
    .compare_default_load(cdl), .crc_scan_source(crc), .reset_pin_function(pin_fn),
    .nvm_write_block(nvm_block), .reset_pin_out_disable(pin_off),
    .chip_erase_flash(er_f), .chip_erase_eeprom(er_e)
  );

  // pulse counters; pulses last one cycle so each edge sees them once
  always @(posedge hclk)
  begin
    if (cdl === 1'b1) n_cdl++;
    if (er_f === 1'b1) n_ef++;
    if (er_e === 1'b1) n_ee++;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic conclude;
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // wait for hready high at a rising edge, never open-ended
  task automatic wait_rdy;
    int n;
    n = 0;
    @(posedge hclk);
    while (hready !== 1'b1)
    begin
      n++;
      if (n > 20)
      begin
        fails++;
        conclude();
      end
      @(posedge hclk);
    end
  endtask

  // one single-word transfer; read data taken at the data phase's last edge
  task automatic bus(input logic wr, input logic [5:0] idx, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {24'h0, idx, 2'b00};
    hwrite <= wr;
    htrans <= 2'b10;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
  endtask

  task automatic chk_rd(input logic [5:0] idx, input logic [31:0] ex);
    bus(1'b0, idx, 32'h0);
    `CHK("hrdata", ex, rd)
  endtask

  task automatic slow_edge;
    slow_osc_in <= 1'b1;
    repeat (3) @(posedge hclk);
    slow_osc_in <= 1'b0;
    repeat (3) @(posedge hclk);
  endtask

  // reset with a fuse image, then check every derived field and both hold-offs
  task automatic do_reset(input fcl_fuse_s f, input logic por);
    int b;
    fcl_cal_s c;
    logic en, ep;
    c = (f.osc.osc_frequency_select == FCL_FREQ_16M) ? cal16 : cal20;
    en = por & ~f.sys.write_block_disable & (f.sys.reset_pin_function != FCL_PIN_DEBUG);
    ep = (f.sys.reset_pin_function == FCL_PIN_GPIO);
    fuse_in <= f;
    por_flag <= por;
    hresetn <= 1'b0;
    repeat (16) @(posedge hclk);
    `CHK("reset nvm block", 1'b1, nvm_block)
    `CHK("reset pin off", 1'b1, pin_off)
    b = n_cdl;
    hresetn <= 1'b1;
    repeat (3) @(posedge hclk);
    // later fuse changes must not reach the outputs
    fuse_in <= ~f;
    repeat (2) @(posedge hclk);
    `CHK("wdt", f.wdt, wdt_control)
    `CHK("bod", f.bod, bod_control)
    `CHK("freq", f.osc.osc_frequency_select, freq)
    `CHK("cal_a", c.osc_coarse_calibration, cal_a)
    `CHK("cal_b", {f.osc.osc_calib_lock, c.osc_temp_calibration}, cal_b)
    `CHK("fault ctrl", f.tcd, tdf)
    `CHK("crc", f.sys.crc_scan_source, crc)
    `CHK("pin fn", f.sys.reset_pin_function, pin_fn)
    `CHK("default loads", b + 1, n_cdl)
    for (int i = 0; i < 5; i++)
      chk_rd((i < 3) ? 6'(i) : 6'(i + 1), {24'h0, f[39 - 8 * i -: 8]});
    `CHK("nvm hold", en, nvm_block)
    `CHK("pin hold", ep, pin_off)
    repeat (HOLD - 1) slow_edge();
    repeat (6) @(posedge hclk);
    `CHK("nvm hold late", en, nvm_block)
    `CHK("pin hold late", ep, pin_off)
    slow_edge();
    repeat (6) @(posedge hclk);
    `CHK("nvm released", 1'b0, nvm_block)
    `CHK("pin released", 1'b0, pin_off)
    bus(1'b0, FCL_IDX_STATUS, 32'h0);
    `CHK("status", 3'b001, rd[2:0])
    $display("end of reset load test");
  endtask

  // chip erase request; flash always, eeprom as expected
  task automatic erase(input int ee);
    int bf, be;
    bf = n_ef;
    be = n_ee;
    bus(1'b1, FCL_IDX_CTRL, 32'h2);
    repeat (3) @(posedge hclk);
    `CHK("erase flash", bf + 1, n_ef)
    `CHK("erase eeprom", be + ee, n_ee)
    $display("end of erase test");
  endtask

  // debug entry reapplies default levels only with fault on debug set
  task automatic dbg(input logic en);
    int b;
    bus(1'b1, FCL_IDX_CTRL, {31'h0, en});
    b = n_cdl;
    debug_entry <= 1'b1;
    @(posedge hclk);
    debug_entry <= 1'b0;
    repeat (3) @(posedge hclk);
    `CHK("debug defaults", b + int'(en), n_cdl)
    $display("end of debug test");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    do_reset({8'ha5, 8'h5e, 8'h01, 8'h9c, 8'h01}, 1'b1);
    bus(1'b1, FCL_IDX_WDT, 32'hff);
    chk_rd(FCL_IDX_WDT, 32'ha5);
    chk_rd(6'h03, 32'h0);
    `CHK("hresp", 1'b0, hresp)
    bus(1'b1, FCL_IDX_CAL_A, 32'h3c);
    chk_rd(FCL_IDX_CAL_A, 32'h3c);
    erase(0);
    dbg(1'b1);
    dbg(1'b0);
    device_locked <= 1'b1;
    do_reset({8'h5a, 8'he1, 8'h82, 8'h63, 8'hd5}, 1'b0);
    bus(1'b1, FCL_IDX_CAL_A, 32'h11);
    // let the refused write's data-phase edge settle before looking
    @(posedge hclk);
    `CHK("locked cal_a", cal20.osc_coarse_calibration, cal_a)
    erase(1);
    device_locked <= 1'b0;
    do_reset({8'h0f, 8'h00, 8'h03, 8'h00, 8'h48}, 1'b1);
    erase(1);
    conclude();
  end

  // hang guard
  initial
  begin
    repeat (50000) @(posedge hclk);
    fails++;
    conclude();
  end
endmodule

`default_nettype wire

// ===== rtl/fcl_loader.sv
// fuse configuration loader: samples the fuse bytes after each reset and drives
// the derived control fields of watchdog, brown-out, oscillator, timer D, crc scan,
// nvm write block and reset pin; registers reachable over an AHB-Lite slave.
// assumes fuse bytes, factory calibration, por flag, lock and debug are hclk-synchronous;
// the slow oscillator arrives from another domain and is synchronised here.
//
// The AHB-Lite slave port was decided locally.

`timescale 1ns/1ps
`default_nettype none

module fcl_loader
  import fcl_pkg::*;
#(
  parameter int BLOCK_CYCLES = FCL_HOLD_SLOW_CYCLES
)
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // nonvolatile sources, device status, slow oscillator and debug entry
  input wire fcl_fuse_s fuse_in,
  input wire fcl_cal_s factory_cal_16m,
  input wire fcl_cal_s factory_cal_20m,
  input wire logic por_flag,
  input wire logic device_locked,
  input wire logic slow_osc_in,
  input wire logic debug_entry,
  // watchdog and brown-out fields
  output fcl_wdt_s wdt_control,
  output fcl_bod_s bod_control,
  // main oscillator
  output logic [1:0] osc_frequency_select,
  output logic [7:0] osc_calibration_a,
  output logic [7:0] osc_calibration_b,
  // timer D
  output logic [7:0] timer_d_fault_control,
  output logic compare_default_load,
  // system
  output logic [1:0] crc_scan_source,
  output logic [1:0] reset_pin_function,
  output logic nvm_write_block,
  output logic reset_pin_out_disable,
  output logic chip_erase_flash,
  output logic chip_erase_eeprom
);

  ////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    fcl_state_e fsm;
    fcl_fuse_s fuse;
    logic slow_sync1;
    logic slow_sync2;
    logic slow_prev;
    logic [9:0] slow_count;
    logic nvm_block;
    logic pin_off;
    logic [7:0] cal_a;
    logic [6:0] cal_b_temp;
    logic fault_on_debug;
    logic compare_load;
    logic erase_flash;
    logic erase_eeprom;
    logic ahb_wr;
    logic [5:0] ahb_idx;
    logic [31:0] rdata;
  } fcl_regs_s;

  localparam fcl_regs_s FCL_REGS_RESET = '{
    fsm: FCL_LOAD,
    fuse: {FCL_WDT_RESET, FCL_BOD_RESET, FCL_OSC_RESET, FCL_TCD_RESET, FCL_SYS_RESET},
    slow_count: 10'h000,
    nvm_block: 1'b1,
    pin_off: 1'b1,
    cal_a: 8'h00,
    cal_b_temp: 7'h00,
    rdata: 32'h0000_0000,
    ahb_idx: 6'h00,
    default: 1'b0
  };

  localparam logic [9:0] LAST_COUNT = 10'(BLOCK_CYCLES - 1);

  fcl_regs_s st;
  fcl_regs_s next_st;
  logic slow_rise;
  logic addr_phase;
  logic cal_write_ok;

  ////////////////////////////////////////////////////////////////////////////
  // next-state logic

  always_comb
  begin
    next_st = st;
    next_st.compare_load = 1'b0;
    next_st.erase_flash = 1'b0;
    next_st.erase_eeprom = 1'b0;
    // two-flop synchroniser, edge taken from second and third stages only
    next_st.slow_sync1 = slow_osc_in;
    next_st.slow_sync2 = st.slow_sync1;
    next_st.slow_prev = st.slow_sync2;
    slow_rise = st.slow_sync2 & ~st.slow_prev;
    addr_phase = hsel & hready & htrans[1];
    cal_write_ok = ~st.fuse.osc.osc_calib_lock;

    unique case (st.fsm)
      FCL_LOAD:
      begin
        // single capture after reset release, held afterwards
        next_st.fuse = fuse_in;
        // factory calibration follows the frequency select
        if (fuse_in.osc.osc_frequency_select == FCL_FREQ_16M)
        begin
          next_st.cal_a = factory_cal_16m.osc_coarse_calibration;
          next_st.cal_b_temp = factory_cal_16m.osc_temp_calibration;
        end
        else
        begin
          // reserved codes fall back to the 20 MHz set
          next_st.cal_a = factory_cal_20m.osc_coarse_calibration;
          next_st.cal_b_temp = factory_cal_20m.osc_temp_calibration;
        end
        next_st.compare_load = 1'b1;
        // write block only after power-on, pin general i/o or reset, not disabled
        next_st.nvm_block = por_flag & ~fuse_in.sys.write_block_disable &
          (fuse_in.sys.reset_pin_function == FCL_PIN_GPIO ||
           fuse_in.sys.reset_pin_function == FCL_PIN_RESET);
        // pin driver held off after every reset when general i/o
        next_st.pin_off = fuse_in.sys.reset_pin_function == FCL_PIN_GPIO;
        next_st.slow_count = 10'h000;
        if (next_st.nvm_block | next_st.pin_off)
          next_st.fsm = FCL_COUNT;
        else
          next_st.fsm = FCL_DONE;
      end
      FCL_COUNT:
      begin
        // count slow oscillator cycles, then release both holds
        if (slow_rise)
        begin
          if (st.slow_count == LAST_COUNT)
          begin
            next_st.nvm_block = 1'b0;
            next_st.pin_off = 1'b0;
            next_st.fsm = FCL_DONE;
          end
          else
            next_st.slow_count = st.slow_count + 10'h001;
        end
      end
      FCL_DONE:
      begin
        next_st.slow_count = st.slow_count;
      end
    endcase

    // debug entry reapplies default levels when enabled
    if (debug_entry & st.fault_on_debug)
      next_st.compare_load = 1'b1;

    // data phase of a write: registers update here
    if (st.ahb_wr)
    begin
      unique case (st.ahb_idx)
        FCL_IDX_CTRL:
        begin
          next_st.fault_on_debug = hwdata[FCL_CTRL_FAULT_DBG_BIT];
          if (hwdata[FCL_CTRL_ERASE_BIT])
          begin
            next_st.erase_flash = 1'b1;
            // eeprom erased unless kept, always when locked
            next_st.erase_eeprom = device_locked | ~st.fuse.sys.eeprom_keep_on_erase;
          end
        end
        FCL_IDX_CAL_A:
        begin
          if (cal_write_ok)
            next_st.cal_a = hwdata[7:0];
        end
        FCL_IDX_CAL_B:
        begin
          if (cal_write_ok)
            next_st.cal_b_temp = hwdata[6:0];
        end
        default:
        begin
          next_st.cal_a = next_st.cal_a;
        end
      endcase
    end

    // address phase: latch write target, build read data from updated state
    next_st.ahb_wr = addr_phase & hwrite;
    if (addr_phase)
      next_st.ahb_idx = haddr[7:2];
    next_st.rdata = 32'h0000_0000;
    if (addr_phase & ~hwrite)
    begin
      unique case (haddr[7:2])
        FCL_IDX_WDT: next_st.rdata[7:0] = next_st.fuse.wdt;
        FCL_IDX_BOD: next_st.rdata[7:0] = next_st.fuse.bod;
        FCL_IDX_OSC: next_st.rdata[7:0] = next_st.fuse.osc;
        FCL_IDX_TCD: next_st.rdata[7:0] = next_st.fuse.tcd;
        FCL_IDX_SYS: next_st.rdata[7:0] = next_st.fuse.sys;
        FCL_IDX_CTRL: next_st.rdata[FCL_CTRL_FAULT_DBG_BIT] = next_st.fault_on_debug;
        FCL_IDX_CAL_A: next_st.rdata[7:0] = next_st.cal_a;
        FCL_IDX_CAL_B:
          next_st.rdata[7:0] = {next_st.fuse.osc.osc_calib_lock, next_st.cal_b_temp};
        FCL_IDX_STATUS:
        begin
          next_st.rdata[FCL_STAT_LOADED_BIT] = next_st.fsm != FCL_LOAD;
          next_st.rdata[FCL_STAT_NVM_BLOCK_BIT] = next_st.nvm_block;
          next_st.rdata[FCL_STAT_PIN_OFF_BIT] = next_st.pin_off;
          next_st.rdata[25:16] = next_st.slow_count;
        end
        default: next_st.rdata = 32'h0000_0000;  // unmapped reads zero
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register: constants only under reset

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      st <= FCL_REGS_RESET;
    else
      st <= next_st;
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs straight from state flops, except the constant hreadyout and hresp

  // zero wait states, always okay
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = st.rdata;
  assign wdt_control = st.fuse.wdt;
  assign bod_control = st.fuse.bod;
  assign osc_frequency_select = st.fuse.osc.osc_frequency_select;
  assign osc_calibration_a = st.cal_a;
  assign osc_calibration_b = {st.fuse.osc.osc_calib_lock, st.cal_b_temp};
  // fault control gets the whole timer D byte
  assign timer_d_fault_control = st.fuse.tcd;
  assign compare_default_load = st.compare_load;
  assign crc_scan_source = st.fuse.sys.crc_scan_source;
  assign reset_pin_function = st.fuse.sys.reset_pin_function;
  assign nvm_write_block = st.nvm_block;
  assign reset_pin_out_disable = st.pin_off;
  assign chip_erase_flash = st.erase_flash;
  assign chip_erase_eeprom = st.erase_eeprom;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  logic in_load;
  assign in_load = st.fsm == FCL_LOAD;

  property p_hold_fuses;
    @(posedge hclk) disable iff (!hresetn)
    !in_load |=> $stable(st.fuse);
  endproperty
  a_hold_fuses: assert property (p_hold_fuses) else $error("fuse shadow changed");

  property p_wdt_window;
    @(posedge hclk) disable iff (!hresetn)
    in_load |=> wdt_control.window == $past(fuse_in.wdt.window);
  endproperty
  a_wdt_window: assert property (p_wdt_window) else $error("window not loaded");

  property p_wdt_period;
    @(posedge hclk) disable iff (!hresetn)
    in_load ##1 !in_load [*3] |-> wdt_control.period == $past(fuse_in.wdt.period, 3);
  endproperty
  a_wdt_period: assert property (p_wdt_period) else $error("period not held");

  property p_bod_level;
    @(posedge hclk) disable iff (!hresetn)
    in_load |=> bod_control.brownout_threshold == $past(fuse_in.bod.brownout_threshold);
  endproperty
  a_bod_level: assert property (p_bod_level) else $error("threshold wrong");

  property p_bod_rate;
    @(posedge hclk) disable iff (!hresetn)
    in_load |=> bod_control.brownout_sample_rate == $past(fuse_in.bod.brownout_sample_rate);
  endproperty
  a_bod_rate: assert property (p_bod_rate) else $error("sample rate wrong");

  property p_bod_active;
    @(posedge hclk) disable iff (!hresetn)
    in_load |=> bod_control.active_mode == $past(fuse_in.bod.active_mode);
  endproperty
  a_bod_active: assert property (p_bod_active) else $error("active mode wrong");

  property p_bod_sleep;
    @(posedge hclk) disable iff (!hresetn)
    in_load |=> bod_control.sleep_mode == $past(fuse_in.bod.sleep_mode);
  endproperty
  a_bod_sleep: assert property (p_bod_sleep) else $error("sleep mode wrong");

  property p_cal_locked;
    @(posedge hclk) disable iff (!hresetn)
    st.ahb_wr && st.fuse.osc.osc_calib_lock && !in_load |=> $stable(osc_calibration_a);
  endproperty
  a_cal_locked: assert property (p_cal_locked) else $error("locked cal written");

  property p_freq_16m;
    @(posedge hclk) disable iff (!hresetn)
    in_load && fuse_in.osc.osc_frequency_select == FCL_FREQ_16M
      |=> osc_calibration_a == $past(factory_cal_16m.osc_coarse_calibration);
  endproperty
  a_freq_16m: assert property (p_freq_16m) else $error("16 MHz cal wrong");

  property p_tcd_byte;
    @(posedge hclk) disable iff (!hresetn)
    in_load |=> timer_d_fault_control == $past(fuse_in.tcd);
  endproperty
  a_tcd_byte: assert property (p_tcd_byte) else $error("fault control wrong");

  property p_pin_enable;
    @(posedge hclk) disable iff (!hresetn)
    in_load |=> timer_d_fault_control[7:4] == $past(fuse_in.tcd.pin_enable);
  endproperty
  a_pin_enable: assert property (p_pin_enable) else $error("pin enables wrong");

  property p_debug_reload;
    @(posedge hclk) disable iff (!hresetn)
    debug_entry && st.fault_on_debug |=> compare_default_load;
  endproperty
  a_debug_reload: assert property (p_debug_reload) else $error("no reload on debug");

  property p_crc_src;
    @(posedge hclk) disable iff (!hresetn)
    in_load |=> crc_scan_source == $past(fuse_in.sys.crc_scan_source);
  endproperty
  a_crc_src: assert property (p_crc_src) else $error("crc source wrong");

  property p_block_len;
    @(posedge hclk) disable iff (!hresetn)
    $fell(nvm_write_block) && !$past(in_load) |-> $past(st.slow_count) == LAST_COUNT;
  endproperty
  a_block_len: assert property (p_block_len) else $error("write block too short");

  property p_block_off;
    @(posedge hclk) disable iff (!hresetn)
    in_load && fuse_in.sys.write_block_disable |=> !nvm_write_block;
  endproperty
  a_block_off: assert property (p_block_off) else $error("block despite disable");

  property p_pin_func;
    @(posedge hclk) disable iff (!hresetn)
    in_load |=> reset_pin_function == $past(fuse_in.sys.reset_pin_function);
  endproperty
  a_pin_func: assert property (p_pin_func) else $error("pin function wrong");

  property p_pin_off;
    @(posedge hclk) disable iff (!hresetn)
    in_load && fuse_in.sys.reset_pin_function == FCL_PIN_GPIO
      |=> reset_pin_out_disable [*8];
  endproperty
  a_pin_off: assert property (p_pin_off) else $error("pin driver released early");

  property p_keep_eeprom;
    @(posedge hclk) disable iff (!hresetn)
    chip_erase_flash && !chip_erase_eeprom |-> $past(!device_locked);
  endproperty
  a_keep_eeprom: assert property (p_keep_eeprom) else $error("eeprom kept wrongly");

  property p_locked_erase;
    @(posedge hclk) disable iff (!hresetn)
    st.ahb_wr && st.ahb_idx == FCL_IDX_CTRL && hwdata[FCL_CTRL_ERASE_BIT] && device_locked
      |=> chip_erase_eeprom && chip_erase_flash;
  endproperty
  a_locked_erase: assert property (p_locked_erase) else $error("locked erase kept eeprom");

endmodule

`default_nettype wire

// ===== rtl/fcl_pkg.sv
// fuse configuration loader: shared constants, register map and carrier types
// assumes fuse bytes are stable, clock-synchronous levels while the loader samples them

package fcl_pkg;

  // register indices; byte address is four times the index
  localparam logic [5:0] FCL_IDX_WDT = 6'h00;
  localparam logic [5:0] FCL_IDX_BOD = 6'h01;
  localparam logic [5:0] FCL_IDX_OSC = 6'h02;
  localparam logic [5:0] FCL_IDX_TCD = 6'h04;
  localparam logic [5:0] FCL_IDX_SYS = 6'h05;
  localparam logic [5:0] FCL_IDX_CTRL = 6'h10;
  localparam logic [5:0] FCL_IDX_CAL_A = 6'h11;
  localparam logic [5:0] FCL_IDX_CAL_B = 6'h12;
  localparam logic [5:0] FCL_IDX_STATUS = 6'h13;

  // field positions of the control, status and calibration B registers
  localparam int FCL_CTRL_FAULT_DBG_BIT = 0;
  localparam int FCL_CTRL_ERASE_BIT = 1;
  localparam int FCL_STAT_LOADED_BIT = 0;
  localparam int FCL_STAT_NVM_BLOCK_BIT = 1;
  localparam int FCL_STAT_PIN_OFF_BIT = 2;
  localparam int FCL_CAL_B_LOCK_BIT = 7;

  // shadow reset values
  localparam logic [7:0] FCL_WDT_RESET = 8'h00;
  localparam logic [7:0] FCL_BOD_RESET = 8'h00;
  localparam logic [7:0] FCL_OSC_RESET = 8'h02;
  localparam logic [7:0] FCL_TCD_RESET = 8'h00;
  localparam logic [7:0] FCL_SYS_RESET = 8'hc4;

  // field encodings
  localparam logic [1:0] FCL_FREQ_16M = 2'h1;
  localparam logic [1:0] FCL_FREQ_20M = 2'h2;
  localparam logic [1:0] FCL_PIN_GPIO = 2'h0;
  localparam logic [1:0] FCL_PIN_DEBUG = 2'h1;
  localparam logic [1:0] FCL_PIN_RESET = 2'h2;
  localparam logic [2:0] FCL_THRESHOLD_LOW = 3'h0;
  localparam logic [2:0] FCL_THRESHOLD_MID = 3'h2;
  localparam logic [2:0] FCL_THRESHOLD_HIGH = 3'h7;
  localparam logic [1:0] FCL_CRC_BOOT_AND_APP = 2'h2;
  localparam logic [1:0] FCL_CRC_NONE = 2'h3;

  // slow oscillator cycles of the write block and pin driver hold-off
  localparam int FCL_HOLD_SLOW_CYCLES = 768;

  typedef enum logic [1:0] {
    FCL_LOAD = 2'b00,
    FCL_COUNT = 2'b01,
    FCL_DONE = 2'b11
  } fcl_state_e;

  typedef struct packed {
    logic [3:0] window;
    logic [3:0] period;
  } fcl_wdt_s;

  typedef struct packed {
    logic [2:0] brownout_threshold;
    logic brownout_sample_rate;
    logic [1:0] active_mode;
    logic [1:0] sleep_mode;
  } fcl_bod_s;

  typedef struct packed {
    logic osc_calib_lock;
    logic [4:0] unused;
    logic [1:0] osc_frequency_select;
  } fcl_osc_s;

  typedef struct packed {
    logic [3:0] pin_enable;
    logic [3:0] default_level;
  } fcl_tcd_s;

  typedef struct packed {
    logic [1:0] crc_scan_source;
    logic unused;
    logic write_block_disable;
    logic [1:0] reset_pin_function;
    logic unused0;
    logic eeprom_keep_on_erase;
  } fcl_sys_s;

  typedef struct packed {
    fcl_wdt_s wdt;
    fcl_bod_s bod;
    fcl_osc_s osc;
    fcl_tcd_s tcd;
    fcl_sys_s sys;
  } fcl_fuse_s;

  typedef struct packed {
    logic [7:0] osc_coarse_calibration;
    logic [6:0] osc_temp_calibration;
  } fcl_cal_s;

endpackage
